// ===== dual_encoder_counter_latch.v
// Added by the designer: the APB register port.
`include "dual_encoder_counter_latch_map.vh"

module dual_encoder_counter_latch (
   input wire i_clock,
   input wire i_nrst,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [7:0] i_paddr,
   input wire [31:0] i_pwdata,
   output reg [31:0] o_prdata,
   output reg o_pready,
   output reg o_pslverr,
   input wire i_ch1_track_a,
   input wire i_ch1_track_b,
   input wire i_ch1_zero_track,
   input wire i_ch1_first_sensor_track,
   input wire i_ch1_second_sensor_track,
   input wire i_ch1_ref_cam,
   input wire i_ch1_sense_error,
   input wire i_ch2_track_a,
   input wire i_ch2_track_b,
   input wire i_ch2_zero_track,
   input wire i_ch2_first_sensor_track,
   input wire i_ch2_second_sensor_track,
   input wire i_ch2_ref_cam,
   input wire i_ch2_sense_error,
   input wire i_slot_trigger
);

   // ************************************************
   // input synchronisers
   // ************************************************
   wire [`IN_TOTAL-1:0] raw_in;
   reg [`IN_TOTAL-1:0] meta_q;
   reg [`IN_TOTAL-1:0] in_q;
   reg [`IN_TOTAL-1:0] prev_q;

   assign raw_in = {
      i_slot_trigger,
      i_ch2_sense_error,
      i_ch2_ref_cam,
      i_ch2_second_sensor_track,
      i_ch2_first_sensor_track,
      i_ch2_zero_track,
      i_ch2_track_b,
      i_ch2_track_a,
      i_ch1_sense_error,
      i_ch1_ref_cam,
      i_ch1_second_sensor_track,
      i_ch1_first_sensor_track,
      i_ch1_zero_track,
      i_ch1_track_b,
      i_ch1_track_a
   };

   genvar k;
   generate
      for (k = 0; k < `IN_TOTAL; k = k + 1) begin : sync
         // edges are taken from in_q against prev_q, never from meta_q
         always @(posedge i_clock or negedge i_nrst) begin
            if (!i_nrst) begin
               meta_q[k] <= 1'b0;
               in_q[k] <= 1'b0;
               prev_q[k] <= 1'b0;
            end else begin
               meta_q[k] <= raw_in[k];
               in_q[k] <= meta_q[k];
               prev_q[k] <= in_q[k];
            end
         end
      end
   endgenerate

   wire trig_rise;
   assign trig_rise = in_q[`IN_TOTAL-1] & ~prev_q[`IN_TOTAL-1];

   // ************************************************
   // register bus
   // ************************************************
   reg [15:0] cmd;
   reg [3:0] clr_pulse;
   reg [1:0] pre_we;
   reg [31:0] pre_val;
   reg [15:0] mode [0:1];

   reg [15:0] next_cmd;
   reg [3:0] next_clr;
   reg [31:0] next_rdata;
   reg next_err;

   wire [5:0] idx;
   wire aligned;
   wire setup;
   wire wr_en;
   wire [15:0] status;

   assign idx = i_paddr[7:2];
   assign aligned = (i_paddr[1:0] == 2'b00);
   assign setup = i_psel & ~i_penable;
   assign wr_en = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;

   // command update: word path and bit path share one register
   always @* begin
      next_cmd = cmd;
      next_clr = 4'h0;
      if (wr_en && idx == `IDX_CMD_WORD) begin
         next_cmd = i_pwdata[15:0] & `CMD_KEEP_MASK;
         next_clr = i_pwdata[11:8];
      end else if (wr_en && idx == `IDX_CMD_BIT) begin
         // clear bits act as pulses and are never stored
         if (i_pwdata[`BITW_NUM_MSB:0] >= 4'd8 && i_pwdata[`BITW_NUM_MSB:0] <= 4'd11) begin
            next_clr[i_pwdata[1:0]] = i_pwdata[`BITW_VAL];
         end else begin
            next_cmd[i_pwdata[`BITW_NUM_MSB:0]] = i_pwdata[`BITW_VAL];
         end
      end
   end

   always @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         cmd <= `CMD_RESET;
         clr_pulse <= 4'h0;
         pre_we <= 2'b00;
         pre_val <= `COUNT_RESET;
         mode[0] <= `MODE_RESET;
         mode[1] <= `MODE_RESET;
      end else begin
         cmd <= next_cmd;
         clr_pulse <= next_clr;
         pre_val <= i_pwdata;
         pre_we[0] <= wr_en & (idx == `IDX_CH1_COUNT) & cmd[`CMD_PRELOAD_BASE];
         pre_we[1] <= wr_en & (idx == `IDX_CH2_COUNT) & cmd[`CMD_PRELOAD_BASE+1];
         if (wr_en && idx == `IDX_CH1_MODE) begin
            mode[0] <= i_pwdata[15:0];
         end
         if (wr_en && idx == `IDX_CH2_MODE) begin
            mode[1] <= i_pwdata[15:0];
         end
      end
   end

   // ************************************************
   // per channel counting and latching
   // ************************************************
   genvar c;
   generate
      for (c = 0; c < 2; c = c + 1) begin : chan
         wire a;
         wire b;
         wire z;
         wire s1;
         wire s2;
         wire cam;
         wire a_p;
         wire b_p;
         wire z_p;
         wire s1_p;
         wire s2_p;
         wire cam_p;
         wire en_s1;
         wire en_s2;
         wire en_cam;
         wire en_zero;
         wire dir_pos;
         wire preload;
         wire pos_cond;
         wire neg_cond;
         wire z_rise;
         reg step;
         reg fwd;
         reg quad;
         reg hold;
         reg [31:0] cnt;
         reg [31:0] snap;
         reg [31:0] lpos;
         reg [31:0] lneg;
         reg zflag;
         reg pflag;
         reg nflag;

         assign a = in_q[c*`IN_PER_CH+0];
         assign b = in_q[c*`IN_PER_CH+1];
         assign z = in_q[c*`IN_PER_CH+2];
         assign s1 = in_q[c*`IN_PER_CH+3];
         assign s2 = in_q[c*`IN_PER_CH+4];
         assign cam = in_q[c*`IN_PER_CH+5];
         assign a_p = prev_q[c*`IN_PER_CH+0];
         assign b_p = prev_q[c*`IN_PER_CH+1];
         assign z_p = prev_q[c*`IN_PER_CH+2];
         assign s1_p = prev_q[c*`IN_PER_CH+3];
         assign s2_p = prev_q[c*`IN_PER_CH+4];
         assign cam_p = prev_q[c*`IN_PER_CH+5];

         assign en_s1 = cmd[`CMD_EN_BASE+4*c+0];
         assign en_s2 = cmd[`CMD_EN_BASE+4*c+1];
         assign en_cam = cmd[`CMD_EN_BASE+4*c+2];
         assign en_zero = cmd[`CMD_EN_BASE+4*c+3];
         assign dir_pos = cmd[`CMD_DIR_BASE+c];
         assign preload = cmd[`CMD_PRELOAD_BASE+c];

         assign z_rise = z & ~z_p;
         // zero track only transfers while the first sensor is high
         assign pos_cond = (en_s1 & ~en_zero & s1 & ~s1_p) |
                           (en_s2 & s2 & ~s2_p) |
                           (en_zero & en_s1 & s1 & z_rise);
         assign neg_cond = (en_s1 & ~en_zero & ~s1 & s1_p) |
                           (en_s2 & ~s2 & s2_p);

         // step decode; an unknown mode value leaves the counter still
         always @* begin
            step = 1'b0;
            quad = 1'b1;
            fwd = 1'b1;
            case (mode[c])
               `MODE_X4: begin
                  step = (a ^ a_p) | (b ^ b_p);
                  fwd = a ^ b_p;
               end
               `MODE_X2: begin
                  step = a ^ a_p;
                  fwd = a ^ b;
               end
               `MODE_X1: begin
                  step = a & ~a_p;
                  fwd = ~b;
               end
               `MODE_FAST: begin
                  step = s1 ^ s1_p;
                  quad = 1'b0;
               end
               default: begin
                  step = 1'b0;
               end
            endcase
            if (quad && !dir_pos) begin
               fwd = ~fwd;
            end
         end

         always @(posedge i_clock or negedge i_nrst) begin
            if (!i_nrst) begin
               cnt <= `COUNT_RESET;
               hold <= 1'b0;
            end else if (pre_we[c]) begin
               cnt <= pre_val;
               hold <= 1'b1;
            end else if (!preload) begin
               hold <= 1'b0;
               if (en_cam && cam && !cam_p) begin
                  cnt <= `COUNT_RESET;
               end else if (step) begin
                  cnt <= fwd ? cnt + 32'h00000001 : cnt - 32'h00000001;
               end
            end else if (!hold) begin
               // preload armed but no value written yet: keep counting
               if (en_cam && cam && !cam_p) begin
                  cnt <= `COUNT_RESET;
               end else if (step) begin
                  cnt <= fwd ? cnt + 32'h00000001 : cnt - 32'h00000001;
               end
            end
         end

         // latch value and flag move on the same edge so a set pflag
         // or nflag never shows a stale latch; a set beats a same-cycle clear
         always @(posedge i_clock or negedge i_nrst) begin
            if (!i_nrst) begin
               snap <= `COUNT_RESET;
               lpos <= `COUNT_RESET;
               lneg <= `COUNT_RESET;
               zflag <= 1'b0;
               pflag <= 1'b0;
               nflag <= 1'b0;
            end else begin
               if (trig_rise) begin
                  snap <= cnt;
               end
               if (pos_cond) begin
                  lpos <= cnt;
                  pflag <= 1'b1;
               end else if (clr_pulse[c]) begin
                  pflag <= 1'b0;
               end
               if (neg_cond) begin
                  lneg <= cnt;
                  nflag <= 1'b1;
               end else if (clr_pulse[c]) begin
                  nflag <= 1'b0;
               end
               if (en_zero && z_rise) begin
                  zflag <= 1'b1;
               end else if (clr_pulse[2+c]) begin
                  zflag <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // ************************************************
   // status word
   // ************************************************
   assign status = {
      chan[1].nflag,
      chan[0].nflag,
      chan[1].pflag,
      chan[0].pflag,
      chan[1].zflag,
      chan[0].zflag,
      2'b00,
      in_q[`IN_PER_CH+6],
      in_q[6],
      in_q[`IN_PER_CH+5],
      in_q[5],
      in_q[`IN_PER_CH+4],
      in_q[`IN_PER_CH+3],
      in_q[4],
      in_q[3]
   };

   // ************************************************
   // read mux and answer
   // ************************************************
   // write-only locations answer reads with an error and zero data
   always @* begin
      next_rdata = 32'h00000000;
      next_err = ~aligned;
      if (i_pwrite) begin
         case (idx)
            `IDX_CH1_COUNT: next_err = next_err;
            `IDX_CMD_WORD: next_err = next_err;
            `IDX_CH1_MODE: next_err = next_err;
            `IDX_CH2_COUNT: next_err = next_err;
            `IDX_CH2_MODE: next_err = next_err;
            `IDX_CMD_BIT: next_err = next_err;
            default: next_err = 1'b1;
         endcase
      end else begin
         case (idx)
            `IDX_CH1_COUNT: next_rdata = chan[0].snap;
            `IDX_CMD_WORD: next_rdata = chan[0].lpos;
            `IDX_STATUS: next_rdata = {16'h0000, status};
            `IDX_CH2_COUNT: next_rdata = chan[1].snap;
            `IDX_CH2_POS_LATCH: next_rdata = chan[1].lpos;
            `IDX_CH1_NEG_LATCH: next_rdata = chan[0].lneg;
            `IDX_CH2_NEG_LATCH: next_rdata = chan[1].lneg;
            default: next_err = 1'b1;
         endcase
         if (next_err) begin
            next_rdata = 32'h00000000;
         end
      end
   end

   // answer is prepared in setup, so every access has no wait state
   always @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         o_prdata <= 32'h00000000;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
      end else if (setup) begin
         o_prdata <= next_rdata;
         o_pready <= 1'b1;
         o_pslverr <= next_err;
      end else begin
         o_prdata <= 32'h00000000;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
      end
   end

endmodule // dual_encoder_counter_latch

// ===== dual_encoder_counter_latch_map.vh
`ifndef DUAL_ENCODER_COUNTER_LATCH_MAP_VH
`define DUAL_ENCODER_COUNTER_LATCH_MAP_VH

// ************************************************
// register indices, byte address is four times these
// ************************************************
`define IDX_CH1_COUNT 6'h00
`define IDX_CMD_WORD 6'h04
`define IDX_CH1_MODE 6'h0a
`define IDX_STATUS 6'h0e
`define IDX_CH2_COUNT 6'h10
`define IDX_CH2_POS_LATCH 6'h14
`define IDX_CH2_MODE 6'h1a
`define IDX_CH1_NEG_LATCH 6'h20
`define IDX_CMD_BIT 6'h24
`define IDX_CH2_NEG_LATCH 6'h30

// ************************************************
// command word fields
// ************************************************
`define CMD_EN_BASE 0
`define CMD_CLR_POS_BASE 8
`define CMD_CLR_ZERO_BASE 10
`define CMD_DIR_BASE 12
`define CMD_PRELOAD_BASE 14
`define CMD_KEEP_MASK 16'hf0ff
`define CMD_RESET 16'h0000

// bit access word: bit number and value
`define BITW_NUM_MSB 3
`define BITW_VAL 4

// ************************************************
// evaluation modes
// ************************************************
`define MODE_X4 16'h0000
`define MODE_X2 16'h0001
`define MODE_X1 16'h0004
`define MODE_FAST 16'h0085
`define MODE_RESET 16'h0000

// ************************************************
// reset values and input layout
// ************************************************
`define COUNT_RESET 32'h00000000
`define IN_PER_CH 7
`define IN_TOTAL 15

`endif

// ===== dual_encoder_counter_latch_chk.sv
module dual_encoder_counter_latch_chk (
   input wire i_clock,
   input wire i_nrst,
   input wire i_psel,
   input wire i_penable,
   input wire i_pwrite,
   input wire [7:0] i_paddr,
   input wire [31:0] o_prdata,
   input wire o_pready,
   input wire o_pslverr,
   input wire i_ch1_first_sensor_track,
   input wire i_ch1_second_sensor_track,
   input wire i_ch2_first_sensor_track,
   input wire i_ch2_second_sensor_track,
   input wire i_ch1_ref_cam,
   input wire i_ch2_ref_cam,
   input wire i_ch1_sense_error,
   input wire i_ch2_sense_error
);
   timeunit 1ns;
   timeprecision 1ns;
   wire [7:0] live = {i_ch2_sense_error, i_ch1_sense_error, i_ch2_ref_cam, i_ch1_ref_cam,
      i_ch2_second_sensor_track, i_ch2_first_sensor_track,
      i_ch1_second_sensor_track, i_ch1_first_sensor_track};
   default clocking dc @(posedge i_clock); endclocking
   default disable iff (!i_nrst);
   // ****************
   // apb answer
   // ****************
   sequence setup(logic [7:0] a, logic w);
      i_psel && !i_penable && i_paddr == a && i_pwrite == w;
   endsequence
   // pins pass two sync flops, so only a steady level can be compared
   sequence steady;
      $stable(live) [*4];
   endsequence
   a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
      else $error("pready missing after setup");
   a_ready_single: assert property (o_pready |=> !o_pready)
      else $error("pready held too long");
   a_ready_cause: assert property (o_pready |-> $past(i_psel && !i_penable))
      else $error("pready without setup");
   a_err_with_ready: assert property (o_pslverr |-> o_pready)
      else $error("pslverr outside access");
   a_data_idle_zero: assert property (!o_pready |-> o_prdata == 32'h0)
      else $error("prdata not zero when idle");
   a_misaligned_err: assert property (i_psel && !i_penable && i_paddr[1:0] != 2'h0 |=> o_pslverr)
      else $error("misaligned access accepted");
   // ****************
   // register access
   // ****************
   a_wo_read_err: assert property (
      i_psel && !i_penable && !i_pwrite && i_paddr inside {8'h28, 8'h68, 8'h90} |=> o_pslverr)
      else $error("write only place was read");
   a_status_no_write: assert property (setup(8'h38, 1'b1) |=> o_pslverr)
      else $error("status write accepted");
   a_status_live: assert property (
      steady ##0 setup(8'h38, 1'b0) |=> o_prdata[7:0] == $past(live) && !o_pslverr)
      else $error("status live bits wrong");
   a_status_reserved: assert property (
      setup(8'h38, 1'b0) |=> o_prdata[9:8] == 2'h0 && o_prdata[31:16] == 16'h0)
      else $error("status reserved bits set");
endmodule // dual_encoder_counter_latch_chk

bind dual_encoder_counter_latch dual_encoder_counter_latch_chk u_dual_encoder_counter_latch_chk (
   .i_clock, .i_nrst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .o_prdata, .o_pready,
   .o_pslverr, .i_ch1_first_sensor_track, .i_ch1_second_sensor_track,
   .i_ch2_first_sensor_track, .i_ch2_second_sensor_track, .i_ch1_ref_cam, .i_ch2_ref_cam,
   .i_ch1_sense_error, .i_ch2_sense_error
);

// ===== encoder_pair_model.sv
module encoder_pair_model (
   input wire i_clock,
   input wire [1:0] i_step,
   output wire [1:0] o_track_a,
   output wire [1:0] o_track_b
);
   timeunit 1ns;
   timeprecision 1ns;
   for (genvar c = 0; c < 2; c++) begin : g_ch
      logic [1:0] phase = 2'h0;
      always @(posedge i_clock) begin
         if (i_step[c]) begin
            phase <= phase + 2'h1;
         end
      end
      // gray order: one track moves per step, so no edge can be lost
      assign o_track_a[c] = phase[1] ^ phase[0];
      assign o_track_b[c] = phase[1];
   end
endmodule // encoder_pair_model

// ===== test_dual_encoder_counter_latch.sv
module test_dual_encoder_counter_latch;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct {logic [7:0] a; logic e; logic [31:0] m; logic [31:0] v;} note_t;
   note_t exp_q[$];
   note_t nt;
   logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trig = 1'b0;
   logic [7:0] paddr = 8'h00, lv = 8'h00;
   logic [31:0] pwdata = 32'h0, p;
   logic [31:0] cur [2];
   logic [1:0] zero = 2'h0, step = 2'h0;
   wire [1:0] ta, tb;
   wire [31:0] prdata;
   wire pready, pslverr;
   int err_total = 0, check_count = 0, seed = 93209;
   logic [7:0] wo [3] = '{8'h28, 8'h68, 8'h90};
   logic [15:0] modes [5] = '{16'h0000, 16'h0001, 16'h0004, 16'h0085, 16'h0000};
   int delta [5] = '{8, 4, 2, 8, -8};
   always #4 clk = ~clk;

   dual_encoder_counter_latch u_dual_encoder_counter_latch (
      .i_clock(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_ch1_track_a(ta[0]), .i_ch1_track_b(tb[0]),
      .i_ch1_zero_track(zero[0]), .i_ch1_first_sensor_track(lv[0]),
      .i_ch1_second_sensor_track(lv[1]), .i_ch1_ref_cam(lv[4]), .i_ch1_sense_error(lv[6]),
      .i_ch2_track_a(ta[1]), .i_ch2_track_b(tb[1]), .i_ch2_zero_track(zero[1]),
      .i_ch2_first_sensor_track(lv[2]), .i_ch2_second_sensor_track(lv[3]),
      .i_ch2_ref_cam(lv[5]), .i_ch2_sense_error(lv[7]), .i_slot_trigger(trig));
   encoder_pair_model u_encoder_pair_model (
      .i_clock(clk), .i_step(step), .o_track_a(ta), .o_track_b(tb));

   // ****************
   // bus and pins
   // ****************
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
   endtask
   task conclude();
      if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
      input logic e);
      int k;
      exp_q.push_back('{a, e, m, d});
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      // the request stands until pready is seen high at a rising edge
      @(posedge clk);
      while (pready !== 1'b1 && k < 20) begin
         @(posedge clk);
         k++;
      end
      if (k == 20) err_total++;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, 32'h0, 1'b0);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
      bus(1'b0, a, v, m, 1'b0);
   endtask
   task steps(input int c, input int n);
      repeat (n) begin
         step[c] <= 1'b1;
         tk(1);
         step[c] <= 1'b0;
         tk(4);
      end
   endtask
   task pulse();
      trig <= 1'b1;
      tk(5);
      trig <= 1'b0;
      tk(5);
   endtask

   always @(negedge clk) begin
      if (pready === 1'b1) begin
         if (exp_q.size() == 0) begin
            err_total++;
            $display("unexpected pready: expected 0 seen 1");
         end else begin
            nt = exp_q.pop_front();
            check_count++;
            if (pslverr !== nt.e || (prdata & nt.m) !== (nt.v & nt.m)) begin
               err_total++;
               $display("unexpected reply at %h: expected %h/%b seen %h/%b", nt.a,
                  nt.v & nt.m, nt.e, prdata & nt.m, pslverr);
            end
         end
      end
   end

   initial begin
      tk(30000);
      err_total++;
      conclude();
   end

   // ****************
   // scenarios
   // ****************
   initial begin
      tk(3);
      nrst <= 1'b1;
      rd(8'h38, 32'h0, 32'hffffffff);
      rd(8'h00, 32'h0, 32'hffffffff);
      foreach (wo[i]) bus(1'b0, wo[i], 32'h0, 32'hffffffff, 1'b1);
      bus(1'b1, 8'h38, 32'hffff, 32'h0, 1'b1);
      bus(1'b1, 8'h01, 32'h0, 32'h0, 1'b1);
      bus(1'b1, 8'h04, 32'h0, 32'h0, 1'b1);
      repeat (4) begin
         lv <= 8'($random(seed));
         tk(6);
         rd(8'h38, {24'h0, lv}, 32'hffffffff);
      end
      lv <= 8'h00;
      for (int c = 0; c < 2; c++) begin
         for (int k = 0; k < 5; k++) begin
            p = $random(seed);
            wr(8'h10, (k < 4) ? 32'h3000 : 32'h0);
            wr(8'h90, 32'(30 + c));
            wr(c ? 8'h40 : 8'h00, p);
            steps(c, 2);
            pulse();
            rd(c ? 8'h40 : 8'h00, p, 32'hffffffff);
            wr(8'h90, 32'(14 + c));
            wr(c ? 8'h68 : 8'h28, {16'h0, modes[k]});
            if (k == 3) begin
               repeat (8) begin
                  lv[2*c] <= ~lv[2*c];
                  tk(5);
               end
            end else steps(c, 8);
            pulse();
            cur[c] = p + 32'(delta[k]);
            rd(c ? 8'h40 : 8'h00, cur[c], 32'hffffffff);
         end
      end
      for (int c = 0; c < 2; c++) begin
         wr(8'h10, 32'h3000 | (32'h1 << 4*c));
         lv[2*c] <= 1'b1;
         tk(6);
         rd(8'h38, 32'h1 << (12 + c), 32'h1 << (12 + c));
         rd(c ? 8'h50 : 8'h10, cur[c], 32'hffffffff);
         lv[2*c] <= 1'b0;
         tk(6);
         rd(8'h38, 32'h5 << (12 + c), 32'h5 << (12 + c));
         rd(c ? 8'hc0 : 8'h80, cur[c], 32'hffffffff);
         wr(8'h10, 32'h3000 | (32'h1 << 4*c) | (32'h100 << c));
         tk(3);
         rd(8'h38, 32'h0, 32'h5 << (12 + c));
         wr(8'h10, 32'h3000 | (32'h9 << 4*c));
         lv[2*c] <= 1'b1;
         tk(6);
         zero[c] <= 1'b1;
         tk(6);
         rd(8'h38, 32'h5 << (10 + c), 32'h5 << (10 + c));
         wr(8'h90, 32'(26 + c));
         tk(3);
         rd(8'h38, 32'h4 << (10 + c), 32'h5 << (10 + c));
         zero[c] <= 1'b0;
         lv[2*c] <= 1'b0;
         wr(8'h10, 32'h3000 | (32'h4 << 4*c));
         lv[4+c] <= 1'b1;
         tk(6);
         pulse();
         rd(c ? 8'h40 : 8'h00, 32'h0, 32'hffffffff);
         lv[4+c] <= 1'b0;
      end
      tk(5);
      if (exp_q.size() != 0) err_total++;
      conclude();
   end
endmodule // test_dual_encoder_counter_latch
